// >>> rtl/dcf_defines.vh
`ifndef DCF_DEFINES_VH
`define DCF_DEFINES_VH

// buffer geometry
`define DCF_ADDR_W        13
`define DCF_DEPTH         8192
`define DCF_DATA_W        9

// flag offset defaults, empty+7 and full-7
`define DCF_EOFS_DEFAULT  16'h0007
`define DCF_FOFS_DEFAULT  16'h0007

// load sequence positions of the four offset bytes
`define DCF_SEL_E_LO      2'h0
`define DCF_SEL_E_HI      2'h1
`define DCF_SEL_F_LO      2'h2
`define DCF_SEL_F_HI      2'h3

// strapped pin modes
`define DCF_MODE_LOAD     1'b0
`define DCF_MODE_TWO_WEN  1'b1

// bus register byte offsets
`define DCF_REG_CTRL      8'h00
`define DCF_REG_STATUS    8'h04
`define DCF_REG_OFFSETS   8'h08
`define DCF_REG_POINTERS  8'h0C

// control register fields
`define DCF_CTRL_SWRST    0

// status register fields
`define DCF_ST_FULL_N     0
`define DCF_ST_AFULL_N    1
`define DCF_ST_AEMPTY_N   2
`define DCF_ST_EMPTY_N    3
`define DCF_ST_MODE       4

// pointer register field positions
`define DCF_PTR_W_LSB     0
`define DCF_PTR_R_LSB     16

`endif

// >>> rtl/dcf_sync2.v
`timescale 1ns/10ps
`default_nettype none

// two-stage pointer carrier; first stage feeds only the second
module dcf_sync2 #(
  parameter W = 14
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_r;  // first stage, read only by q

  // shift the gray word through two flops
  always @(posedge clk)
  begin
    if (rst)
    begin
      meta_r <= {W{1'b0}};
      q      <= {W{1'b0}};
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/dcf_fifo_top.v
// Notes on behaviour
// R1: full flag low at 8192 words stored
// R2: full side flags move on write edges
// R3: empty flag low when pointers match
// R4: empty side flags move on read edges
// R5: almost-full low at m free, default 7
// R6: almost-empty low at n words, default 7
// R7: empty side flag table by word count
// R8: full side flag table by word count
// R9: load pin strapped during reset picks mode
// R10: output zero after reset, float when disabled
// R11: pin clocks may run during reset
// R12: full flag may lag one write edge
// R13: first word readable after one or two reads
// R14: almost-full may lag one write edge
// R15: almost-empty may lag one read edge
// R16: nine-bit words in and out
// R17: single use ties second read enable low
// R18: wide use combines empty and full flags
// R19: two-enable mode keeps default offsets
// R20: depth expansion steers one enable each
// R21: reset clears pointers, output, offsets, flags
// R22: load writes four offset bytes, wraps
// R23: writes ignored while full
// R24: read needs both enables low, not empty
// R25: pointers cross sides gray coded, two stages
// R26: pointers carry one extra wrap bit
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "dcf_defines.vh"

module dcf_fifo_top #(
  parameter AW    = `DCF_ADDR_W,   // address bits of the store
  parameter DEPTH = `DCF_DEPTH,    // words held when full
  parameter DW    = `DCF_DATA_W    // word width
) (
  input  wire          CLK_SYS,
  input  wire          RST,
  input  wire          HSEL,
  input  wire [31:0]   HADDR,
  input  wire [1:0]    HTRANS,
  input  wire          HWRITE,
  input  wire [2:0]    HSIZE,
  input  wire [31:0]   HWDATA,
  input  wire          HREADY,
  output reg  [31:0]   HRDATA,
  output reg           HREADYOUT,
  output reg           HRESP,
  input  wire          RESET_N,
  input  wire          WRITE_CLOCK,
  input  wire [DW-1:0] WRITE_DATA_BUS,
  input  wire          WRITE_ENABLE_A_N,
  input  wire          WRITE_ENABLE_B_OR_LOAD_N,
  input  wire          READ_CLOCK,
  input  wire          READ_ENABLE_A_N,
  input  wire          READ_ENABLE_B_N,
  input  wire          OUTPUT_ENABLE_N,
  output reg  [DW-1:0] READ_DATA_BUS,
  output reg           READ_DATA_BUS_OE,
  output reg           FULL_FLAG_N,
  output reg           ALMOST_FULL_FLAG_N,
  output reg           EMPTY_FLAG_N,
  output reg           ALMOST_EMPTY_FLAG_N
);

  localparam PW = AW + 1;                   // pointer width with wrap bit
  localparam [PW-1:0] DEPTH_P  = DEPTH[PW-1:0];     // full count, pointer width
  localparam [16:0]   DEPTH_W  = DEPTH[16:0];       // full count, offset math
  localparam [15:0]   EOFS_DEF = `DCF_EOFS_DEFAULT; // empty offset after reset
  localparam [15:0]   FOFS_DEF = `DCF_FOFS_DEFAULT; // full offset after reset

  //////////////////////////////////////////////////////////////////////////
  // helpers

  // gray to binary, folding from the top bit down
  function [PW-1:0] gray2bin;
    input [PW-1:0] g;
    integer i;
    begin
      gray2bin[PW-1] = g[PW-1];
      for (i = PW - 2; i >= 0; i = i - 1)
        gray2bin[i] = gray2bin[i+1] ^ g[i];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // declarations

  reg  [DW-1:0] mem [0:DEPTH-1];     // word store
  reg           ctrl_swrst_r;        // software held reset
  reg           mode_r;              // strapped pin mode
  reg           wclk_q_r;            // last sample of write clock pin
  reg           rclk_q_r;            // last sample of read clock pin
  reg  [PW-1:0] wptr_r;              // binary write pointer
  reg  [PW-1:0] wgray_r;             // gray copy for the read side
  reg  [PW-1:0] rptr_r;              // binary read pointer
  reg  [PW-1:0] rgray_r;             // gray copy for the write side
  reg  [7:0]    eofs_lo_r;           // empty offset low byte
  reg  [7:0]    eofs_hi_r;           // empty offset high byte
  reg  [7:0]    fofs_lo_r;           // full offset low byte
  reg  [7:0]    fofs_hi_r;           // full offset high byte
  reg  [1:0]    wsel_r;              // next offset byte to load
  reg  [1:0]    rsel_r;              // next offset byte to show
  reg           ahb_act_r;           // write data phase pending
  reg  [7:0]    ahb_addr_r;          // latched address of that phase
  reg  [31:0]   rd_nxt;              // read mux for the bus
  wire          dev_rst;             // any reset source
  wire          w_evt;               // rising edge on the write clock pin
  wire          r_evt;               // rising edge on the read clock pin
  wire [PW-1:0] rgray_s;             // read pointer seen by write side
  wire [PW-1:0] wgray_s;             // write pointer seen by read side
  wire [PW-1:0] rsync_bin;           // decoded read pointer, write side
  wire [PW-1:0] wsync_bin;           // decoded write pointer, read side
  wire          fifo_wr;             // word accepted this cycle
  wire          ofs_wr;              // offset byte loaded this cycle
  wire          fifo_rd;             // word popped this cycle
  wire          ofs_rd;              // offset byte shown this cycle
  wire [PW-1:0] wptr_nxt;            // write pointer after this edge
  wire [PW-1:0] rptr_nxt;            // read pointer after this edge
  wire [PW-1:0] wcount;              // fill as seen by write side
  wire [PW-1:0] rcount;              // fill as seen by read side
  wire [15:0]   n_eff;               // empty offset in force
  wire [15:0]   m_eff;               // full offset in force
  wire [16:0]   af_sum;              // fill plus full offset
  wire          ahb_take;            // valid address phase

  //////////////////////////////////////////////////////////////////////////
  // reset and pin edges

  // pin reset, bus reset and software reset all restart the buffer
  assign dev_rst = RST | ~RESET_N | ctrl_swrst_r;

  // pins are synchronous samples, so a one-flop history finds the edges;
  // the pin clocks are watched through pin and software reset, so running them then is harmless
  assign w_evt = WRITE_CLOCK & ~wclk_q_r;   // see R11
  assign r_evt = READ_CLOCK & ~rclk_q_r;    // see R11

  // edge history for both pin clocks
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      wclk_q_r <= 1'b0;
      rclk_q_r <= 1'b0;
    end
    else
    begin
      wclk_q_r <= WRITE_CLOCK;
      rclk_q_r <= READ_CLOCK;
    end
  end

  // strap: the last level seen while reset is held decides the mode
  always @(posedge CLK_SYS)
  begin
    if (dev_rst)
      mode_r <= WRITE_ENABLE_B_OR_LOAD_N;   // see R9
  end

  //////////////////////////////////////////////////////////////////////////
  // write side

  // a word goes in with enable a low and the second pin high, either mode
  assign fifo_wr = w_evt & ~WRITE_ENABLE_A_N & WRITE_ENABLE_B_OR_LOAD_N
                 & FULL_FLAG_N;                      // see R23
  // offset bytes only in load mode with the load pin low
  assign ofs_wr  = w_evt & ~WRITE_ENABLE_A_N & ~WRITE_ENABLE_B_OR_LOAD_N
                 & (mode_r == `DCF_MODE_LOAD);       // see R22

  assign wptr_nxt = fifo_wr ? wptr_r + 1'b1 : wptr_r;  // see R26

  // store and advance the write pointer
  always @(posedge CLK_SYS)
  begin
    if (dev_rst)
    begin
      wptr_r  <= {PW{1'b0}};                         // see R21
      wgray_r <= {PW{1'b0}};
    end
    else if (fifo_wr)
    begin
      mem[wptr_r[AW-1:0]] <= WRITE_DATA_BUS;         // see R16
      wptr_r  <= wptr_nxt;
      wgray_r <= wptr_nxt ^ (wptr_nxt >> 1);         // see R25
    end
  end

  // offset byte load, cycling empty lo, empty hi, full lo, full hi
  always @(posedge CLK_SYS)
  begin
    if (dev_rst)
    begin
      eofs_lo_r <= EOFS_DEF[7:0];                    // see R21
      eofs_hi_r <= EOFS_DEF[15:8];
      fofs_lo_r <= FOFS_DEF[7:0];
      fofs_hi_r <= FOFS_DEF[15:8];
      wsel_r    <= `DCF_SEL_E_LO;
    end
    else if (ofs_wr)
    begin
      case (wsel_r)
        `DCF_SEL_E_LO: eofs_lo_r <= WRITE_DATA_BUS[7:0];   // see R22
        `DCF_SEL_E_HI: eofs_hi_r <= WRITE_DATA_BUS[7:0];
        `DCF_SEL_F_LO: fofs_lo_r <= WRITE_DATA_BUS[7:0];
        default:       fofs_hi_r <= WRITE_DATA_BUS[7:0];
      endcase
      wsel_r <= wsel_r + 2'h1;                       // wraps after four
    end
  end

  // two-enable mode cannot load, so defaults always apply there
  assign n_eff = (mode_r == `DCF_MODE_TWO_WEN) ? `DCF_EOFS_DEFAULT
               : {eofs_hi_r, eofs_lo_r};             // see R19
  assign m_eff = (mode_r == `DCF_MODE_TWO_WEN) ? `DCF_FOFS_DEFAULT
               : {fofs_hi_r, fofs_lo_r};             // see R19

  //////////////////////////////////////////////////////////////////////////
  // pointer crossing

  // read pointer toward the write side
  dcf_sync2 #(
    .W (PW)
  ) u_rptr_sync (
    .clk (CLK_SYS),
    .rst (dev_rst),
    .d   (rgray_r),
    .q   (rgray_s)
  );

  // write pointer toward the read side
  dcf_sync2 #(
    .W (PW)
  ) u_wptr_sync (
    .clk (CLK_SYS),
    .rst (dev_rst),
    .d   (wgray_r),
    .q   (wgray_s)
  );

  assign rsync_bin = gray2bin(rgray_s);              // see R25
  assign wsync_bin = gray2bin(wgray_s);              // see R25

  //////////////////////////////////////////////////////////////////////////
  // full side flags

  // the wrap bit makes a full store differ from an empty one
  assign wcount = wptr_nxt - rsync_bin;              // see R26
  assign af_sum = {{(17-PW){1'b0}}, wcount} + {1'b0, m_eff};

  // flags move only on write pin edges; a read seen through the carrier
  // shows up one or more write edges late, never early, which is safe
  always @(posedge CLK_SYS)
  begin
    if (dev_rst)
    begin
      FULL_FLAG_N        <= 1'b1;                    // see R21
      ALMOST_FULL_FLAG_N <= 1'b1;
    end
    else if (w_evt)                                  // see R2
    begin
      FULL_FLAG_N        <= ~(wcount == DEPTH_P);    // see R1, R8, R12
      ALMOST_FULL_FLAG_N <= ~(af_sum >= DEPTH_W);    // see R5, R8, R14
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read side

  // both enables low; the load pin low in load mode shows an offset byte
  assign ofs_rd  = r_evt & ~READ_ENABLE_A_N & ~READ_ENABLE_B_N
                 & ~WRITE_ENABLE_B_OR_LOAD_N
                 & (mode_r == `DCF_MODE_LOAD);
  assign fifo_rd = r_evt & ~READ_ENABLE_A_N & ~READ_ENABLE_B_N & ~ofs_rd
                 & EMPTY_FLAG_N;                     // see R24

  assign rptr_nxt = fifo_rd ? rptr_r + 1'b1 : rptr_r;

  // output register and read pointer
  always @(posedge CLK_SYS)
  begin
    if (dev_rst)
    begin
      rptr_r        <= {PW{1'b0}};                   // see R21
      rgray_r       <= {PW{1'b0}};
      READ_DATA_BUS <= {DW{1'b0}};                   // see R10, R21
      rsel_r        <= `DCF_SEL_E_LO;
    end
    else if (fifo_rd)
    begin
      READ_DATA_BUS <= mem[rptr_r[AW-1:0]];          // see R16, R24
      rptr_r        <= rptr_nxt;
      rgray_r       <= rptr_nxt ^ (rptr_nxt >> 1);   // see R25
    end
    else if (ofs_rd)
    begin
      // same byte order as the load sequence, top bit reads zero
      case (rsel_r)
        `DCF_SEL_E_LO: READ_DATA_BUS <= {1'b0, eofs_lo_r};
        `DCF_SEL_E_HI: READ_DATA_BUS <= {1'b0, eofs_hi_r};
        `DCF_SEL_F_LO: READ_DATA_BUS <= {1'b0, fofs_lo_r};
        default:       READ_DATA_BUS <= {1'b0, fofs_hi_r};
      endcase
      rsel_r <= rsel_r + 2'h1;
    end
  end

  // output drive follows the enable pin, one cycle behind
  always @(posedge CLK_SYS)
  begin
    if (RST)
      READ_DATA_BUS_OE <= 1'b0;
    else
      READ_DATA_BUS_OE <= ~OUTPUT_ENABLE_N;          // see R10
  end

  //////////////////////////////////////////////////////////////////////////
  // empty side flags

  assign rcount = wsync_bin - rptr_nxt;

  // flags move only on read pin edges; a fresh write needs the carrier's
  // two stages, so the first word appears one or two read edges later
  always @(posedge CLK_SYS)
  begin
    if (dev_rst)
    begin
      EMPTY_FLAG_N        <= 1'b0;                   // see R21
      ALMOST_EMPTY_FLAG_N <= 1'b0;
    end
    else if (r_evt)                                  // see R4
    begin
      EMPTY_FLAG_N        <= (rcount != {PW{1'b0}}); // see R3, R7, R13
      ALMOST_EMPTY_FLAG_N <= ({{(16-PW){1'b0}}, rcount} > n_eff);
                                                     // see R6, R7, R15
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bus slave

  // never stalls, so only hready gates a new address phase
  assign ahb_take = HSEL & HTRANS[1] & HREADY;

  // read mux, unmapped offsets answer zero
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    case (HADDR[7:0])
      `DCF_REG_CTRL:
        rd_nxt[`DCF_CTRL_SWRST] = ctrl_swrst_r;
      `DCF_REG_STATUS:
      begin
        rd_nxt[`DCF_ST_FULL_N]   = FULL_FLAG_N;
        rd_nxt[`DCF_ST_AFULL_N]  = ALMOST_FULL_FLAG_N;
        rd_nxt[`DCF_ST_AEMPTY_N] = ALMOST_EMPTY_FLAG_N;
        rd_nxt[`DCF_ST_EMPTY_N]  = EMPTY_FLAG_N;
        rd_nxt[`DCF_ST_MODE]     = mode_r;
      end
      `DCF_REG_OFFSETS:
        rd_nxt = {m_eff, n_eff};
      `DCF_REG_POINTERS:
      begin
        rd_nxt[`DCF_PTR_W_LSB +: PW] = wptr_r;
        rd_nxt[`DCF_PTR_R_LSB +: PW] = rptr_r;
      end
      default:
        rd_nxt = 32'h0000_0000;                      // unmapped
    endcase
  end

  // address phase latch, read data staged for the data phase
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      ahb_act_r  <= 1'b0;
      ahb_addr_r <= 8'h00;
      HRDATA     <= 32'h0000_0000;
      HREADYOUT  <= 1'b1;
      HRESP      <= 1'b0;
    end
    else
    begin
      HREADYOUT <= 1'b1;                             // zero wait states
      HRESP     <= 1'b0;                             // always okay
      if (HREADY)
      begin
        ahb_act_r  <= ahb_take & HWRITE;
        ahb_addr_r <= HADDR[7:0];
      end
      if (ahb_take & ~HWRITE)
        HRDATA <= rd_nxt;
    end
  end

  // control write lands in the data phase
  always @(posedge CLK_SYS)
  begin
    if (RST)
      ctrl_swrst_r <= 1'b0;
    else if (ahb_act_r && ahb_addr_r == `DCF_REG_CTRL)
      ctrl_swrst_r <= HWDATA[`DCF_CTRL_SWRST];
  end

endmodule

`default_nettype wire

// >>> sim/dcf_fifo_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// watches flag pins, read port and bus answer of the buffer
module dcf_fifo_monitor #(
  parameter DW = 9
) (
  input wire logic          CLK_SYS,
  input wire logic          RST,
  input wire logic          HREADYOUT,
  input wire logic          HRESP,
  input wire logic          RESET_N,
  input wire logic          WRITE_CLOCK,
  input wire logic          WRITE_ENABLE_B_OR_LOAD_N,
  input wire logic          READ_CLOCK,
  input wire logic          READ_ENABLE_A_N,
  input wire logic          READ_ENABLE_B_N,
  input wire logic          OUTPUT_ENABLE_N,
  input wire logic [DW-1:0] READ_DATA_BUS,
  input wire logic          READ_DATA_BUS_OE,
  input wire logic          FULL_FLAG_N,
  input wire logic          ALMOST_FULL_FLAG_N,
  input wire logic          EMPTY_FLAG_N,
  input wire logic          ALMOST_EMPTY_FLAG_N
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  // pin clock rise, looked at one system cycle after it was taken
  sequence s_wedge;
    $past(WRITE_CLOCK) && !$past(WRITE_CLOCK, 2);
  endsequence
  // read pin clock rise, looked at one system cycle after it was taken
  sequence s_redge;
    $past(READ_CLOCK) && !$past(READ_CLOCK, 2);
  endsequence
  // enabled read edge; both enables must have been low
  sequence s_pop;
    $past(READ_CLOCK) && !$past(READ_CLOCK, 2) && !$past(READ_ENABLE_A_N)
      && !$past(READ_ENABLE_B_N);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  pin_reset_a: assert property (
    !RESET_N |=> FULL_FLAG_N && ALMOST_FULL_FLAG_N && !EMPTY_FLAG_N
      && !ALMOST_EMPTY_FLAG_N && READ_DATA_BUS == '0)
    else $error("flags or data not cleared by pin reset");
  full_on_wedge_a: assert property (
    $fell(FULL_FLAG_N) || $fell(ALMOST_FULL_FLAG_N) |-> s_wedge)
    else $error("full side flag fell without a write edge");
  empty_on_redge_a: assert property (
    $rose(EMPTY_FLAG_N) || $rose(ALMOST_EMPTY_FLAG_N) |-> s_redge)
    else $error("empty side flag rose without a read edge");
  full_afull_a: assert property (
    !FULL_FLAG_N |-> !ALMOST_FULL_FLAG_N)
    else $error("full without almost full");
  empty_aempty_a: assert property (
    !EMPTY_FLAG_N |-> !ALMOST_EMPTY_FLAG_N)
    else $error("empty without almost empty");
  data_on_pop_a: assert property (
    $changed(READ_DATA_BUS) |-> s_pop or (READ_DATA_BUS == '0))
    else $error("read data moved without an enabled read edge");
  empty_hold_a: assert property (
    READ_CLOCK && !$past(READ_CLOCK) && !EMPTY_FLAG_N && RESET_N
      && WRITE_ENABLE_B_OR_LOAD_N |=> $stable(READ_DATA_BUS))
    else $error("word popped while empty");
  oe_follow_a: assert property (
    !RST |=> READ_DATA_BUS_OE == !$past(OUTPUT_ENABLE_N))
    else $error("output enable not followed");
  bus_okay_a: assert property (
    !RST |=> HREADYOUT && !HRESP)
    else $error("bus answer not ready and okay");
endmodule
bind dcf_fifo_top dcf_fifo_monitor #(.DW(DW)) i_mon (.CLK_SYS(CLK_SYS),
  .RST(RST), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RESET_N(RESET_N),
  .WRITE_CLOCK(WRITE_CLOCK),
  .WRITE_ENABLE_B_OR_LOAD_N(WRITE_ENABLE_B_OR_LOAD_N),
  .READ_CLOCK(READ_CLOCK), .READ_ENABLE_A_N(READ_ENABLE_A_N),
  .READ_ENABLE_B_N(READ_ENABLE_B_N), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
  .READ_DATA_BUS(READ_DATA_BUS), .READ_DATA_BUS_OE(READ_DATA_BUS_OE),
  .FULL_FLAG_N(FULL_FLAG_N), .ALMOST_FULL_FLAG_N(ALMOST_FULL_FLAG_N),
  .EMPTY_FLAG_N(EMPTY_FLAG_N), .ALMOST_EMPTY_FLAG_N(ALMOST_EMPTY_FLAG_N));
`default_nettype wire

// >>> sim/dcf_pin_agent.sv
`timescale 1ns/10ps
`default_nettype none
// writer and reader logic on the pin side; pin clocks rest low
module dcf_pin_agent (
  input  wire logic       clk,
  output var  logic       wclk,
  output var  logic [8:0] wdata,
  output var  logic       wen_a_n,
  output var  logic       rclk,
  output var  logic       ren_a_n,
  output var  logic       ren_b_n
);
  // idle levels at time zero
  initial
  begin
    wclk    = 1'b0;
    wdata   = 9'h000;
    wen_a_n = 1'b1;
    rclk    = 1'b0;
    ren_a_n = 1'b1;
    ren_b_n = 1'b0;
  end
  // one write clock period of two system cycles
  // enable a is the steered one, the bench holds the other
  task automatic wr(input logic [8:0] d, input logic en_n);
    @(posedge clk);
    wclk    <= 1'b1;
    wdata   <= d;
    wen_a_n <= en_n;
    @(posedge clk);
    wclk    <= 1'b0;
    // released bus shows the inverse, never a stale copy
    wdata   <= ~d;
    wen_a_n <= 1'b1;
  endtask
  // one read clock period; second enable goes back to its tied level
  task automatic rd(input logic a_n, input logic b_n);
    @(posedge clk);
    rclk    <= 1'b1;
    ren_a_n <= a_n;
    ren_b_n <= b_n;
    @(posedge clk);
    rclk    <= 1'b0;
    ren_a_n <= 1'b1;
    ren_b_n <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> sim/dual_clock_fifo_status_flags_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dual_clock_fifo_status_flags_tb;
  logic        clk_sys, rst, hwrite, reset_n, ld_n, oe_n, ready;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic        hresp, oe, full_n, afull_n, empty_n, aempty_n;
  logic        wclk, wen_n, rclk, ren_a_n, ren_b_n;
  logic [8:0]  wdata, rdata;
  int          errors, samples_checked, cyc;
  dcf_fifo_top i_dut (.CLK_SYS(clk_sys), .RST(rst), .HSEL(1'b1),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(ready), .HRDATA(hrdata), .HREADYOUT(ready),
    .HRESP(hresp), .RESET_N(reset_n), .WRITE_CLOCK(wclk),
    .WRITE_DATA_BUS(wdata), .WRITE_ENABLE_A_N(wen_n),
    .WRITE_ENABLE_B_OR_LOAD_N(ld_n), .READ_CLOCK(rclk),
    .READ_ENABLE_A_N(ren_a_n), .READ_ENABLE_B_N(ren_b_n),
    .OUTPUT_ENABLE_N(oe_n), .READ_DATA_BUS(rdata), .READ_DATA_BUS_OE(oe),
    .FULL_FLAG_N(full_n), .ALMOST_FULL_FLAG_N(afull_n),
    .EMPTY_FLAG_N(empty_n), .ALMOST_EMPTY_FLAG_N(aempty_n));
  dcf_pin_agent i_pins (.clk(clk_sys), .wclk(wclk), .wdata(wdata),
    .wen_a_n(wen_n), .rclk(rclk), .ren_a_n(ren_a_n), .ren_b_n(ren_b_n));
  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // hang guard, well above the roughly 17k cycles of the run
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      errors++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // single word transfer; waits on ready, no fixed latency assumed
  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (ready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (ready !== 1'b1);
    r = hrdata;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, string n);
    ahb(a, 1'b0, 32'h0, q);
    chk(n, e, q);
  endtask
  // flags as {full, almost full, empty, almost empty}, active low
  // one device, so these are already the composite flags
  task automatic fl(input logic [3:0] e);
    @(negedge clk_sys);
    chk("flags", {28'h0, e}, {28'h0, full_n, afull_n, empty_n, aempty_n});
  endtask
  task automatic do_reset(input logic l);
    @(posedge clk_sys);
    ld_n <= l;
    rst  <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    fl(4'hC);
    chk("rdata", 32'h0, {23'h0, rdata});
    rreg(8'h04, 32'h3, "status");
    rreg(8'h08, 32'h00070007, "offsets");
    rreg(8'h10, 32'h0, "unmapped");
    oe_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("oe", 32'h0, {31'h0, oe});
    oe_n <= 1'b0;
    ld_n <= 1'b1;
    $display("reset test done");
  endtask
  // fill past n, drain in order, then read while empty
  task automatic t_empty;
    int i;
    i_pins.wr(9'h100, 1'b0);
    i_pins.rd(1'b0, 1'b1);
    i_pins.rd(1'b0, 1'b1);
    fl(4'hE);
    chk("no pop", 32'h0, {23'h0, rdata});
    for (i = 1; i < 8; i++)
      i_pins.wr({1'b1, i[7:0]}, 1'b0);
    i_pins.rd(1'b1, 1'b0);
    i_pins.rd(1'b1, 1'b0);
    fl(4'hF);
    for (i = 0; i < 8; i++)
    begin
      i_pins.rd(1'b0, 1'b0);
      @(negedge clk_sys);
      chk("pop", {23'h0, 1'b1, i[7:0]}, {23'h0, rdata});
    end
    fl(4'hC);
    i_pins.rd(1'b0, 1'b0);
    @(negedge clk_sys);
    chk("hold", 32'h107, {23'h0, rdata});
    $display("empty test done");
  endtask
  // n = 5 after a wrap over four bytes, m = 3
  task automatic t_load;
    ld_n <= 1'b0;
    i_pins.wr(9'h102, 1'b0);
    i_pins.wr(9'h000, 1'b0);
    i_pins.wr(9'h003, 1'b0);
    i_pins.wr(9'h000, 1'b0);
    i_pins.wr(9'h005, 1'b0);
    rreg(8'h08, 32'h00030005, "offsets");
    i_pins.rd(1'b0, 1'b0);
    @(negedge clk_sys);
    chk("offset read", 32'h5, {23'h0, rdata});
    ld_n <= 1'b1;
    $display("load test done");
  endtask
  task automatic t_full;
    int i;
    for (i = 0; i < 8188; i++)
      i_pins.wr(i[8:0], 1'b0);
    fl(4'hC);
    i_pins.wr(9'h0AA, 1'b0);
    fl(4'h8);
    i_pins.wr(9'h0AB, 1'b0);
    i_pins.wr(9'h0AC, 1'b0);
    fl(4'h8);
    i_pins.wr(9'h0AD, 1'b0);
    fl(4'h0);
    i_pins.wr(9'h0AE, 1'b0);
    rreg(8'h0C, 32'h00082008, "pointers");
    // first read edge only refreshes the empty side, the second pops
    i_pins.rd(1'b1, 1'b0);
    i_pins.rd(1'b0, 1'b0);
    @(negedge clk_sys);
    chk("first out", 32'h0, {23'h0, rdata});
    // the freed slot reaches the write side one write edge late
    i_pins.wr(9'h000, 1'b1);
    i_pins.wr(9'h000, 1'b1);
    fl(4'hB);
    $display("full test done");
  endtask
  // strap high: second enable, no offset loading
  task automatic t_twoen;
    rreg(8'h04, 32'h13, "status");
    ld_n <= 1'b0;
    i_pins.wr(9'h001, 1'b0);
    rreg(8'h08, 32'h00070007, "offsets");
    rreg(8'h0C, 32'h0, "pointers");
    ld_n <= 1'b1;
    i_pins.wr(9'h0AA, 1'b0);
    rreg(8'h0C, 32'h1, "pointers");
    $display("two enable test done");
  endtask
  task automatic t_soft;
    i_pins.rd(1'b1, 1'b0);
    i_pins.rd(1'b1, 1'b0);
    fl(4'hE);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    @(posedge clk_sys);
    reset_n <= 1'b1;
    fl(4'hC);
    rreg(8'h0C, 32'h0, "pointers");
    i_pins.wr(9'h055, 1'b0);
    ahb(8'h00, 1'b1, 32'h1, q);
    ahb(8'h00, 1'b1, 32'h0, q);
    rreg(8'h0C, 32'h0, "pointers");
    $display("soft reset test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, reset_n} = 2'b11;
    {hwrite, ld_n, oe_n} = 3'b000;
    {errors, samples_checked, cyc} = '0;
    htrans = 2'h0;
    haddr  = 32'h0;
    hwdata = 32'h0;
    do_reset(1'b0);
    t_reset;
    t_empty;
    t_load;
    t_full;
    do_reset(1'b1);
    t_twoen;
    t_soft;
    final_report;
  end
endmodule
`default_nettype wire
